// [ebt_ext_source.sv]
// External edge source for the count pin
// Changes only after hclk edges; each level lasts 3 cycles
`timescale 1ns/1ns
`default_nettype none
module ebt_ext_source (
  input wire logic hclk,
  output logic ext_count_input
);
  initial ext_count_input = 1'b0;
  // Three cycles a level, longer than the sync needs
  task automatic toggle(input int n);
    repeat (n) begin
      ext_count_input <= !ext_count_input;
      repeat (3) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

// [ebt_map.svh]
// Offsets, fields, reset values and timing for the eight-bit timer
// Included by the timer only; definitions only
`ifndef EBT_MAP_SVH
`define EBT_MAP_SVH

`define EBT_OFF_COUNT 8'h00
`define EBT_OFF_OPTION 8'h04
`define EBT_OFF_FLAG 8'h08
`define EBT_OFF_SLEEP 8'h0C
`define EBT_ADDR_BITS 8

`define EBT_OPT_RATE_LSB 0
`define EBT_OPT_BYPASS_BIT 3
`define EBT_OPT_EDGE_BIT 4
`define EBT_OPT_SOURCE_BIT 5
`define EBT_OPT_RESET 8'hFF

`define EBT_FLAG_OVF_BIT 0
`define EBT_FLAG_IE_BIT 1

`define EBT_CLK_HZ 10000000
`define EBT_INSTR_NS 400
`define EBT_INSTR_CYCLES ((`EBT_INSTR_NS * (`EBT_CLK_HZ / 1000000)) / 1000)
`define EBT_HOLD_INSTR 2

`endif

// [ebt_pkg.sv]
// Types shared by the eight-bit timer
// Uses nothing from ebt_map.svh
package ebt_pkg;
  typedef struct packed {
    logic [1:0] htrans;
    logic hsel;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic hready;
  } ebt_ahb_req_t;

  typedef struct packed {
    logic source_select;
    logic edge_select;
    logic bypass;
    logic [2:0] rate_code;
  } ebt_option_t;
endpackage

// [ebt_properties.sv]
// Port checker for the eight-bit timer
// Bound to ebt_timer; one clock, reset low
`timescale 1ns/1ns
`default_nettype none
module ebt_properties (
  // Clock, reset and bus
  input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hrdata,
  // Timer side
  input wire logic sleep_in, overflow_pulse, overflow_flag, overflow_interrupt_enable
);
  logic rd_q, fw_q;
  wire take = hsel & hready & htrans[1];
  // Marks the data phase of reads and of flag writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      fw_q <= 1'b0;
    end else begin
      rd_q <= take & !hwrite;
      fw_q <= take & hwrite & (haddr[7:0] == 8'h08);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Sync takes two flops, so allow slack
  sequence s_asleep; sleep_in [*5]; endsequence
  sequence s_flag_wr; $past(fw_q); endsequence
  chk_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
  chk_ready_high: assert property (hreadyout) else $error("wait state");
  chk_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0) else $error("stray data");
  chk_read_width: assert property (rd_q |-> hrdata[31:8] == 24'h0) else $error("wide");
  chk_pulse_single: assert property (overflow_pulse |=> !overflow_pulse) else $error("long");
  chk_pulse_flag: assert property (overflow_pulse |-> ##[0:1] overflow_flag) else $error("no flag");
  chk_flag_clear: assert property ($fell(overflow_flag) |-> s_flag_wr) else $error("clr");
  chk_ie_write: assert property ($changed(overflow_interrupt_enable) |-> s_flag_wr) else $error("ie");
  chk_sleep_frozen: assert property (s_asleep |-> !overflow_pulse) else $error("slept");
endmodule
`default_nettype wire

// [ebt_timer.sv]
// Eight-bit timer/counter with eight-bit prescaler, AHB-Lite slave
// Assumes one 10 MHz clock; ext_count_input and sleep are asynchronous
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ebt_map.svh"

// Function
// [RULE1] One eight-bit count register runs as timer or external edge counter.
// [RULE2] In timer mode with no prescaler it advances once per instruction cycle.
// [RULE3] Source select at zero picks the instruction clock.
// [RULE4] A software write to the count register holds counting for two instruction cycles.
// [RULE5] Software may adjust the written value to allow for that hold-off.
// [RULE6] In counter mode each selected edge of the external input advances the count.
// [RULE7] Source select at one picks the external input.
// [RULE8] Edge select picks rising (zero) or falling (one) transitions.
// [RULE9] The block owns a private eight-bit prescaler, not shared with the watchdog.
// [RULE10] The overflow is offered as a gate source for the sixteen-bit timer.
// [RULE11] Each wrap from FFh to 00h sets the overflow flag; only software clears it.
// [RULE12] Without bypass the rate code divides by 2 to 256; with bypass the ratio is 1:1.
// [RULE13] The prescaler is hidden from software and cleared by a count register write.
// [RULE14] During sleep the count freezes and no overflow can occur.
// [RULE15] The external input passes two flip-flops before edge detection.
module ebt_timer #(
  parameter int PRESCALE_BITS = 8,
  parameter int INSTR_CYCLES = `EBT_INSTR_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins and neighbours
  input wire logic ext_count_input,
  input wire logic sleep_in,
  output logic overflow_pulse,
  output logic overflow_flag,
  output logic overflow_interrupt_enable
);
  import ebt_pkg::*;

  initial begin
    if (PRESCALE_BITS != 8 || INSTR_CYCLES < 1)
      $error("ebt_timer: unsupported parameters");
  end

  ebt_ahb_req_t req;
  assign req = '{htrans: htrans, hsel: hsel, hwrite: hwrite, hsize: hsize,
                 haddr: haddr, hready: hready};

  // Address phase capture
  logic wr_pend_reg;
  logic [`EBT_ADDR_BITS-1:0] wr_addr_reg;
  wire addr_phase = req.hsel && req.hready && req.htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && req.hwrite;
      if (addr_phase)
        wr_addr_reg <= req.haddr[`EBT_ADDR_BITS-1:0];
    end
  end

  wire wr_count = wr_pend_reg && wr_addr_reg == `EBT_OFF_COUNT;
  wire wr_option = wr_pend_reg && wr_addr_reg == `EBT_OFF_OPTION;
  wire wr_flag = wr_pend_reg && wr_addr_reg == `EBT_OFF_FLAG;

  // Instruction cycle enable
  logic [7:0] div_reg;
  wire instr_tick = div_reg == 8'(INSTR_CYCLES - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      div_reg <= 8'h00;
    else
      div_reg <= instr_tick ? 8'h00 : div_reg + 8'h01;
  end

  // [RULE15] two-stage synchroniser
  logic [2:0] ext_sync_reg;
  logic [1:0] sleep_sync_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_reg <= 3'h0;
      sleep_sync_reg <= 2'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_count_input};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_in};
    end
  end
  wire sleeping = sleep_sync_reg[1];

  ebt_option_t opt_reg;
  // [RULE8] edge polarity choice
  wire ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  wire ext_fall = !ext_sync_reg[1] && ext_sync_reg[2];
  wire ext_edge = opt_reg.edge_select ? ext_fall : ext_rise;
  // [RULE3] [RULE7] source select
  wire src_pulse = opt_reg.source_select ? ext_edge : instr_tick;

  // [RULE9] private prescaler, never readable
  logic [PRESCALE_BITS-1:0] pre_reg;
  logic [PRESCALE_BITS-1:0] pre_next;
  logic [1:0] hold_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  // [RULE12] terminal count per rate code
  wire [PRESCALE_BITS-1:0] pre_last =
    PRESCALE_BITS'((9'h002 << opt_reg.rate_code) - 9'h001);
  wire pre_active = src_pulse && !sleeping && hold_reg == 2'h0;
  wire pre_done = pre_reg == pre_last;
  // [RULE2] [RULE12] bypass gives 1:1
  wire count_step = pre_active && (opt_reg.bypass || pre_done);
  // [RULE13] write clears prescaler
  assign pre_next = wr_count ? '0 :
                    (pre_active && !opt_reg.bypass) ?
                    (pre_done ? '0 : pre_reg + 1'b1) : pre_reg;

  // [RULE11] wrap from FFh
  wire wrap = count_step && count_reg == 8'hFF;
  // [RULE1] [RULE14] count update, frozen in sleep
  assign count_next = wr_count ? hwdata[7:0] :
                      count_step ? count_reg + 8'h01 : count_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= '0;
      count_reg <= 8'h00;
    end else begin
      pre_reg <= pre_next;
      count_reg <= count_next;
    end
  end

  // [RULE4] two instruction cycles hold-off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_reg <= 2'h0;
    else if (wr_count)
      hold_reg <= 2'(`EBT_HOLD_INSTR);
    else if (instr_tick && hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
  end

  // Option register, all ones after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      opt_reg <= ebt_option_t'(6'h3F);
    else if (wr_option)
      opt_reg <= ebt_option_t'(hwdata[5:0]);
  end

  // [RULE11] set beats software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= 1'b0;
      overflow_interrupt_enable <= 1'b0;
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= wrap;
      if (wrap)
        overflow_flag <= 1'b1;
      else if (wr_flag)
        overflow_flag <= hwdata[`EBT_FLAG_OVF_BIT];
      if (wr_flag)
        overflow_interrupt_enable <= hwdata[`EBT_FLAG_IE_BIT];
    end
  end
  // [RULE10] overflow_pulse gates the sixteen-bit timer

  // Read data, taken in the data phase
  wire [`EBT_ADDR_BITS-1:0] rd_sel = wr_addr_reg;
  wire [31:0] rd_word =
    rd_sel == `EBT_OFF_COUNT ? {24'h0, count_reg} :
    rd_sel == `EBT_OFF_OPTION ? {26'h0, opt_reg} :
    rd_sel == `EBT_OFF_FLAG ? {30'h0, overflow_interrupt_enable, overflow_flag} :
    rd_sel == `EBT_OFF_SLEEP ? {31'h0, sleeping} : 32'h00000000;
  logic rd_pend_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rd_pend_reg <= 1'b0;
    else
      rd_pend_reg <= addr_phase && !req.hwrite;
  end
  // Zero outside read data phases
  assign hrdata = rd_pend_reg ? rd_word : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// [test_eight_bit_timer_counter.sv]
// Self-checking bench for the eight-bit timer
// Drives AHB-Lite and the pin source at 10 MHz
`timescale 1ns/1ns
`default_nettype none
module test_eight_bit_timer_counter;
  logic hclk, hresetn, hsel, hwrite, sleep_in;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, overflow_pulse, overflow_flag, overflow_interrupt_enable;
  wire ext_count_input;
  int bad_count, total_checks, n, k;
  ebt_timer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_count_input,
    .sleep_in, .overflow_pulse, .overflow_flag, .overflow_interrupt_enable);
  ebt_ext_source src_u (.hclk, .ext_count_input);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = !hclk;
  end
  task automatic wrap_up(input int late);
    bad_count += late;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for hready or the overflow pulse
  task automatic wait_on(input bit ovf, output int c);
    c = 0;
    do begin
      @(posedge hclk);
      c++;
      if (c > 9000) wrap_up(1);
    end while ((ovf ? overflow_pulse : hreadyout) !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_on(0, c);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(0, c);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  function automatic int edges(logic lvl, int cnt, logic fall);
    edges = 0;
    for (int i = 0; i < cnt; i++) begin
      lvl = !lvl;
      edges += (lvl != fall);
    end
  endfunction
  initial begin
    {hsel, hwrite, sleep_in, hresetn} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(18));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(8'h04, 32'h3F);
    bus(1'b1, 8'h10, 32'hFF);
    rchk(8'h10, 32'h0);
    bus(1'b1, 8'h04, 32'h08);
    bus(1'b1, 8'h00, 32'hFF);
    wait_on(1, n);
    check(n >= 10 && n <= 13, 32'h1);
    wait_on(1, n);
    check(n, 32'd1024);
    rchk(8'h08, 32'h1);
    bus(1'b1, 8'h08, 32'h2);
    rchk(8'h08, 32'h2);
    n = $urandom % 3;
    bus(1'b1, 8'h04, n);
    wait_on(1, k);
    wait_on(1, k);
    check(k, 32'd1024 << (n + 1));
    bus(1'b1, 8'h00, 32'hFF);
    wait_on(1, k);
    check(k >= (4 << (n + 1)) + 6 && k <= (4 << (n + 1)) + 9, 32'h1);
    sleep_in <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b0, 8'h00, 32'h0);
    k = rd;
    repeat (40) @(posedge hclk);
    rchk(8'h00, k);
    sleep_in <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      k = 3 + $urandom % 20;
      bus(1'b1, 8'h04, 32'h28 | (e << 4));
      bus(1'b1, 8'h00, 32'h0);
      repeat (12) @(posedge hclk);
      n = edges(ext_count_input, k, e[0]);
      src_u.toggle(k);
      repeat (6) @(posedge hclk);
      rchk(8'h00, n);
    end
    wrap_up(0);
  end
endmodule
bind ebt_timer ebt_properties chk_u (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout,
  .hresp, .htrans, .haddr, .hrdata, .sleep_in, .overflow_pulse, .overflow_flag,
  .overflow_interrupt_enable);
`default_nettype wire
